/* dual_comparator_control.sv */
// comparator control block: registers over ahb-lite, change flag, pin routing
// assumes raw comparator results arrive asynchronously from the analog macro
`timescale 1ns/1ps
module dual_comparator_control
  import cmp_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic [1:0] i_cmp_raw,
  input wire logic [7:0] i_porta_pins,
  input wire logic i_sleep,
  output logic [7:0] o_porta_out,
  output logic [7:0] o_porta_oe,
  output logic o_irq,
  output logic o_wake,
  output mux_sel_t o_mux_sel,
  output ladder_cfg_t o_ladder_cfg,
  output logic o_ladder_pin_drive
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_n;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [1:0] raw_s1_q;
  logic [1:0] raw_s2_q;
  logic [7:0] pin_s1_q;
  logic [7:0] pin_s2_q;
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      raw_s1_q <= 2'h0;
      raw_s2_q <= 2'h0;
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
    end else begin
      raw_s1_q <= i_cmp_raw;
      raw_s2_q <= raw_s1_q;
      pin_s1_q <= i_porta_pins;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  cmp_ctrl_t ctrl_q;
  logic [7:0] ladder_q;
  logic [7:0] core_irq_q;
  logic [7:0] flags2_q;
  logic [7:0] enables2_q;
  logic [7:0] dira_q;
  logic [7:0] analog_sel_q;
  logic [7:0] port_out_q;
  logic [1:0] latched_q;
  cmp_mode_t mode;
  assign mode = cmp_mode_t'(ctrl_q.comparator_mode_field);

  // ----------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------
  logic ph_valid_q;
  logic ph_write_q;
  logic [REG_IDX_W-1:0] ph_idx_q;
  logic addr_take;
  assign addr_take = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ || i_htrans == HTRANS_SEQ);
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_idx_q <= '0;
    end else if (i_hready) begin
      ph_valid_q <= addr_take;
      ph_write_q <= i_hwrite;
      ph_idx_q <= i_haddr[ADDR_W-1:2];
    end
  end
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  logic wr;
  logic [7:0] wd;
  assign wr = ph_valid_q && ph_write_q;
  assign wd = i_hwdata[7:0];

  // read decode in the address phase; data registered for the data phase
  function automatic logic hit(input logic [REG_IDX_W-1:0] idx, input logic [7:0] ofs);
    hit = (idx == ofs);
  endfunction

  logic [REG_IDX_W-1:0] a_idx;
  logic ctrl_access;
  logic [1:0] cur_res;
  assign a_idx = i_haddr[ADDR_W-1:2];
  assign ctrl_access = ph_valid_q && hit(ph_idx_q, OFS_CMP_CTRL);

  // ----------------------------------------
  // result path
  // ----------------------------------------
  // comparator gives high when vin+ > vin-, inversion applied digitally
  logic [1:0] pol_raw;
  assign pol_raw = i_cmp_raw ^ {ctrl_q.second_invert_bit, ctrl_q.first_invert_bit};
  assign cur_res = (mode == MODE_OFF || mode == MODE_RESET_ANALOG) ? 2'h0 :
                   (raw_s2_q ^ {ctrl_q.second_invert_bit, ctrl_q.first_invert_bit});

  logic [7:0] ctrl_rd;
  assign ctrl_rd = {cur_res, ctrl_q.second_invert_bit, ctrl_q.first_invert_bit,
                    ctrl_q.input_switch_bit, ctrl_q.comparator_mode_field};

  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    if (hit(a_idx, OFS_CMP_CTRL)) rd_val = ctrl_rd;
    else if (hit(a_idx, OFS_LADDER)) rd_val = ladder_q;
    else if (hit(a_idx, OFS_CORE_IRQ)) rd_val = core_irq_q;
    else if (hit(a_idx, OFS_FLAGS2)) rd_val = flags2_q;
    else if (hit(a_idx, OFS_ENABLES2)) rd_val = enables2_q;
    else if (hit(a_idx, OFS_DIRA)) rd_val = dira_q;
    else if (hit(a_idx, OFS_ANALOG_SEL)) rd_val = analog_sel_q;
    else if (hit(a_idx, OFS_PORTA)) rd_val = pin_s2_q & ~analog_sel_q;
  end
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_hrdata <= 32'h0000_0000;
    end else if (addr_take && !i_hwrite) begin
      o_hrdata <= {24'h00_0000, rd_val};
    end
  end

  // ----------------------------------------
  // control register writes
  // ----------------------------------------
  // reset alone reloads; sleep and wake never touch it
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= cmp_ctrl_t'(RST_CMP_CTRL);
    end else if (wr && hit(ph_idx_q, OFS_CMP_CTRL)) begin
      ctrl_q <= cmp_ctrl_t'({2'h0, wd[5:0]});
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ladder_q <= RST_LADDER;
      core_irq_q <= RST_CORE_IRQ;
      enables2_q <= RST_ENABLES2;
      dira_q <= RST_DIRA;
      analog_sel_q <= RST_ANALOG_SEL;
      port_out_q <= RST_PORT_OUT;
    end else if (wr) begin
      if (hit(ph_idx_q, OFS_LADDER)) ladder_q <= wd & LADDER_WMASK;
      if (hit(ph_idx_q, OFS_CORE_IRQ)) core_irq_q <= wd;
      if (hit(ph_idx_q, OFS_ENABLES2)) enables2_q <= wd & ENABLES2_WMASK;
      if (hit(ph_idx_q, OFS_DIRA)) dira_q <= (wd & DIRA_WMASK) | DIRA_FORCE;
      if (hit(ph_idx_q, OFS_ANALOG_SEL)) analog_sel_q <= wd;
      if (hit(ph_idx_q, OFS_PORTA)) port_out_q <= wd;
    end
  end

  // ----------------------------------------
  // change detect and flag
  // ----------------------------------------
  // a change landing on the access cycle is absorbed by the relatch
  logic mismatch;
  assign mismatch = |(latched_q ^ cur_res);
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      latched_q <= 2'h0;
    end else if (ctrl_access) begin
      latched_q <= cur_res;
    end
  end

  logic flag_wr;
  assign flag_wr = wr && hit(ph_idx_q, OFS_FLAGS2);
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags2_q <= RST_FLAGS2;
    end else begin
      if (flag_wr) flags2_q <= wd & FLAGS2_WMASK;
      if (mismatch && !ctrl_access) flags2_q[POS_CHANGE_FLAG] <= 1'b1;
    end
  end

  // flag sets regardless of enables
  logic irq_pend;
  assign irq_pend = flags2_q[POS_CHANGE_FLAG] && enables2_q[POS_CHANGE_EN];
  assign o_irq = irq_pend && core_irq_q[POS_PERIPH_EN] && core_irq_q[POS_GLOBAL_EN];
  // wake needs only the source enable, comparator stays alive in sleep
  assign o_wake = i_sleep && irq_pend && mode != MODE_OFF;

  // ----------------------------------------
  // analog mux and ladder
  // ----------------------------------------
  always_comb begin
    o_mux_sel = '0;
    o_mux_sel.powered_first = 1'b1;
    o_mux_sel.powered_second = 1'b1;
    o_mux_sel.first_neg_pin = 2'h0;
    o_mux_sel.second_neg_pin = 2'h1;
    case (mode)
      MODE_RESET_ANALOG, MODE_OFF: begin
        o_mux_sel.powered_first = 1'b0;
        o_mux_sel.powered_second = 1'b0;
      end
      MODE_ONE_INDEP: begin
        o_mux_sel.powered_second = 1'b0;
        o_mux_sel.first_neg_pin = ctrl_q.input_switch_bit ? 2'h3 : 2'h0;
      end
      MODE_REF_INTERNAL: begin
        o_mux_sel.ref_to_positive = 1'b1;
        o_mux_sel.first_neg_pin = ctrl_q.input_switch_bit ? 2'h3 : 2'h0;
        o_mux_sel.second_neg_pin = ctrl_q.input_switch_bit ? 2'h2 : 2'h1;
      end
      default: begin
      end
    endcase
  end
  assign o_ladder_cfg = {ladder_q[POS_LADDER_PWR], ladder_q[POS_LADDER_OE],
                         ladder_q[POS_LADDER_RANGE], ladder_q[3:0]};
  assign o_ladder_pin_drive = ladder_q[POS_LADDER_PWR] && ladder_q[POS_LADDER_OE];

  // ----------------------------------------
  // pin routing
  // ----------------------------------------
  // unsynchronised on purpose: pins follow the analog edge directly
  logic route_pins;
  assign route_pins = (mode == MODE_COMMON_OUT);
  always_comb begin
    o_porta_out = port_out_q;
    if (route_pins) begin
      o_porta_out[POS_PIN_THREE] = pol_raw[0];
      o_porta_out[POS_PIN_FOUR] = pol_raw[1];
    end
  end
  assign o_porta_oe = ~dira_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_RESET_OFF: assert property (@(posedge i_clk_sys) $rose(rst_n) |-> ctrl_q.comparator_mode_field == 3'h7) else $error("control not off after reset");
  AST_RESULT_RO: assert property (@(posedge i_clk_sys) disable iff (!rst_n) (wr && hit(ph_idx_q, OFS_CMP_CTRL)) |=> ctrl_q.comparator_mode_field == $past(wd[2:0]) && {ctrl_q.second_result_bit, ctrl_q.first_result_bit} == 2'h0) else $error("result bits writable");
  AST_FLAG_SET: assert property (@(posedge i_clk_sys) disable iff (!rst_n) (mismatch && !ctrl_access) |=> flags2_q[POS_CHANGE_FLAG]) else $error("flag missed change");
  AST_RELATCH: assert property (@(posedge i_clk_sys) disable iff (!rst_n) ctrl_access |=> latched_q == $past(cur_res)) else $error("no relatch on access");
  AST_FLAG_CLEAR: assert property (@(posedge i_clk_sys) disable iff (!rst_n) (flag_wr && !wd[POS_CHANGE_FLAG] && !mismatch) |=> !flags2_q[POS_CHANGE_FLAG]) else $error("flag did not clear");
  AST_IRQ_GATE: assert property (@(posedge i_clk_sys) disable iff (!rst_n) o_irq |-> enables2_q[POS_CHANGE_EN] && core_irq_q[POS_PERIPH_EN] && core_irq_q[POS_GLOBAL_EN]) else $error("irq without enables");
  AST_REF_MODE: assert property (@(posedge i_clk_sys) disable iff (!rst_n) o_mux_sel.ref_to_positive |-> mode == MODE_REF_INTERNAL) else $error("reference outside mode 010");
  AST_PORT_ANALOG: assert property (@(posedge i_clk_sys) disable iff (!rst_n) (addr_take && !i_hwrite && hit(a_idx, OFS_PORTA)) |=> (o_hrdata[7:0] & $past(analog_sel_q)) == 8'h00) else $error("analog pin read nonzero");
  AST_PIN_DIR: assert property (@(posedge i_clk_sys) disable iff (!rst_n) dira_q[POS_PIN_THREE] |-> !o_porta_oe[POS_PIN_THREE]) else $error("pin driven while input");
  AST_SLEEP_KEEP: assert property (@(posedge i_clk_sys) disable iff (!rst_n) (!$past(wr) && $fell(i_sleep)) |-> $stable(ctrl_q)) else $error("wake changed control");
endmodule

/* cmp_pkg.sv */
// holds the constants, register map and carrier types of the comparator control block
// assumes an ahb-lite master and analog comparator results arriving asynchronously
// Function
// - eight comparator modes chosen by a three-bit mode field
// - result high when positive input exceeds negative input, else low
// - mode 010 puts the internal reference on both positive inputs
// - the two result bits are read-only, writes ignored
// - pin mode 110 drives pins 3 and 4 straight from comparators, unsynchronised
// - port direction bits still gate the pin drivers in that mode
// - bits 5 and 4 invert comparator 2 and comparator 1 results
// - port data reads zero for every pin set as analog input
// - change flag sets when either result differs from its latched copy
// - flag clears only by writing zero; writing one sets it
// - interrupt reaches the core only with all three enables set
// - a change coinciding with a control register read may not set the flag
// - any control register access relatches results and ends the mismatch
// - enabled comparator keeps running in sleep and its interrupt wakes
// - waking from sleep leaves the control register unchanged
// - any reset loads the control register with off mode 111
// - sixteen-tap ladder, tap chosen by register, used as reference in 010
// - ladder has two ranges and a power-down control
// - ladder output may drive an analog pin under an enable bit
// - in 010 the switch bit picks negative inputs: set pins 3/2, clear pins 0/1
// - ladder power bit 7: one powers on, zero powers down
package cmp_pkg;
  // ----------------------------------------
  // register word indices
  // ----------------------------------------
  localparam logic [7:0] OFS_CORE_IRQ = 8'h0B;
  localparam logic [7:0] OFS_FLAGS2 = 8'h0D;
  localparam logic [7:0] OFS_PORTA = 8'h05;
  localparam logic [7:0] OFS_DIRA = 8'h85;
  localparam logic [7:0] OFS_ENABLES2 = 8'h8D;
  localparam logic [7:0] OFS_CMP_CTRL = 8'h9C;
  localparam logic [7:0] OFS_LADDER = 8'h9D;
  localparam logic [7:0] OFS_ANALOG_SEL = 8'h9B;
  // ----------------------------------------
  // index and address widths
  // ----------------------------------------
  localparam int REG_IDX_W = 8;
  localparam int ADDR_W = REG_IDX_W + 2;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_CORE_IRQ = 8'h00;
  localparam logic [7:0] RST_FLAGS2 = 8'h00;
  localparam logic [7:0] RST_DIRA = 8'hFF;
  localparam logic [7:0] RST_ENABLES2 = 8'h00;
  localparam logic [7:0] RST_CMP_CTRL = 8'h07;
  localparam logic [7:0] RST_LADDER = 8'h00;
  localparam logic [7:0] RST_ANALOG_SEL = 8'h7F;
  localparam logic [7:0] RST_PORT_OUT = 8'h00;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int POS_SECOND_RESULT = 7;
  localparam int POS_FIRST_RESULT = 6;
  localparam int POS_SECOND_INV = 5;
  localparam int POS_FIRST_INV = 4;
  localparam int POS_INPUT_SWITCH = 3;
  localparam int POS_CHANGE_FLAG = 6;
  localparam int POS_CHANGE_EN = 6;
  localparam int POS_GLOBAL_EN = 7;
  localparam int POS_PERIPH_EN = 6;
  localparam int POS_LADDER_PWR = 7;
  localparam int POS_LADDER_OE = 6;
  localparam int POS_LADDER_RANGE = 5;
  localparam int POS_PIN_THREE = 3;
  localparam int POS_PIN_FOUR = 4;
  localparam logic [7:0] LADDER_WMASK = 8'hEF;
  localparam logic [7:0] FLAGS2_WMASK = 8'hD0;
  localparam logic [7:0] ENABLES2_WMASK = 8'hD0;
  localparam logic [7:0] DIRA_WMASK = 8'hDF;
  localparam logic [7:0] DIRA_FORCE = 8'h20;
  // ----------------------------------------
  // ahb-lite encodings
  // ----------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // modes
  typedef enum logic [2:0] {
    MODE_RESET_ANALOG = 3'h0,
    MODE_ONE_INDEP = 3'h1,
    MODE_REF_INTERNAL = 3'h2,
    MODE_FOUR_MUX = 3'h3,
    MODE_TWO_COMMON = 3'h4,
    MODE_TWO_INDEP = 3'h5,
    MODE_COMMON_OUT = 3'h6,
    MODE_OFF = 3'h7
  } cmp_mode_t;

  typedef struct packed {
    logic second_result_bit;
    logic first_result_bit;
    logic second_invert_bit;
    logic first_invert_bit;
    logic input_switch_bit;
    logic [2:0] comparator_mode_field;
  } cmp_ctrl_t;

  typedef struct packed {
    logic ladder_power_enable;
    logic ladder_pin_output_enable;
    logic ladder_range_select;
    logic [3:0] ladder_tap;
  } ladder_cfg_t;

  // analog mux selections handed to the comparator macro
  typedef struct packed {
    logic powered_first;
    logic powered_second;
    logic ref_to_positive;
    logic [1:0] first_neg_pin;
    logic [1:0] second_neg_pin;
  } mux_sel_t;
endpackage

/* cmp_analog_model.sv */
// analog far side: two comparators and the reference ladder
// assumes pin levels in 1/96 of supply, driven by the bench
`timescale 1ns/1ps
module cmp_analog_model
  import cmp_pkg::*;
#(
  parameter int SETTLE_NS = 30
)
(
  input wire logic i_slow,
  input wire mux_sel_t i_mux,
  input wire ladder_cfg_t i_lad,
  input wire logic [3:0][7:0] i_lvl,
  input wire logic [7:0] i_pos,
  output logic [1:0] o_cmp_raw
);
  logic [7:0] lad;
  logic [7:0] pos;
  logic [1:0] tgt;
  // ----------------
  // ladder and comparators
  // ----------------
  always_comb begin
    lad = 8'h00;
    if (i_lad.ladder_power_enable) begin
      lad = i_lad.ladder_range_select ? {2'h0, i_lad.ladder_tap, 2'h0}
                                      : 8'h18 + 8'h03 * {4'h0, i_lad.ladder_tap};
    end
    pos = i_mux.ref_to_positive ? lad : i_pos;
    tgt[0] = i_mux.powered_first && (pos > i_lvl[i_mux.first_neg_pin]);
    tgt[1] = i_mux.powered_second && (pos > i_lvl[i_mux.second_neg_pin]);
  end
  // unsettled output is wrong until the delay runs out
  // runs once at start so the output never waits on a missed first event
  always begin
    if (i_slow) begin
      o_cmp_raw <= ~tgt;
      o_cmp_raw <= #(SETTLE_NS) tgt;
    end else begin
      o_cmp_raw <= tgt;
    end
    @(tgt);
  end
endmodule

/* test_dual_comparator_control.sv */
// self-checking bench for the comparator control block
// assumes cmp_analog_model stands at the analog side
`timescale 1ns/1ps
module test_dual_comparator_control;
  import cmp_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_hsel = 1'b0;
  logic [31:0] i_haddr = 32'h0;
  logic [1:0] i_htrans = 2'h0;
  logic i_hwrite = 1'b0;
  logic [2:0] i_hsize = HSIZE_WORD;
  logic [31:0] i_hwdata = 32'h0;
  logic [7:0] i_porta_pins = 8'h00;
  logic i_sleep = 1'b0;
  logic slow = 1'b0;
  logic [3:0][7:0] lvl = '0;
  logic [7:0] pos = 8'h00;
  logic [31:0] o_hrdata;
  logic o_hreadyout, o_hresp, o_irq, o_wake, o_ladder_pin_drive;
  logic [7:0] o_porta_out, o_porta_oe;
  logic [1:0] raw;
  mux_sel_t o_mux_sel;
  ladder_cfg_t o_ladder_cfg;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [7:0] rd, v, pins;
  logic [3:0] tap;
  logic [1:0] inv, e;
  logic sw;
  logic [7:0] ofs_t [6] = '{8'h0B, 8'h0D, 8'h85, 8'h8D, 8'h9C, 8'h9D};
  logic [7:0] rst_t [6] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h07, 8'h00};

  always #2.5 i_clk_sys = ~i_clk_sys;

  dual_comparator_control dual_comparator_control_i (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_cmp_raw(raw),
    .i_porta_pins(i_porta_pins), .i_sleep(i_sleep), .o_porta_out(o_porta_out),
    .o_porta_oe(o_porta_oe), .o_irq(o_irq), .o_wake(o_wake), .o_mux_sel(o_mux_sel),
    .o_ladder_cfg(o_ladder_cfg), .o_ladder_pin_drive(o_ladder_pin_drive));
  cmp_analog_model cmp_analog_model_i (.i_slow(slow), .i_mux(o_mux_sel),
    .i_lad(o_ladder_cfg), .i_lvl(lvl), .i_pos(pos), .o_cmp_raw(raw));

  // ----------------
  // checks and bus cycles
  // ----------------
  task automatic check_reg(input string w, input logic [7:0] x, input logic [7:0] g);
    n_compared++;
    if (g !== x) begin
      fails++;
      $display("mismatch %s expected %h seen %h", w, x, g);
    end
  endtask
  task automatic check_pin(input string w, input logic x, input logic g);
    n_compared++;
    if (g !== x) begin
      fails++;
      $display("mismatch %s expected %b seen %b", w, x, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [7:0] wd);
    @(posedge i_clk_sys);
    i_hsel <= 1'b1;
    i_haddr <= {22'h0, ofs, 2'h0};
    i_htrans <= HTRANS_NONSEQ;
    i_hwrite <= wr;
    do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= {24'h0, wd};
    do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
    rd = o_hrdata[7:0];
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic get(input logic [7:0] a);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic settle();
    repeat (12) @(posedge i_clk_sys);
  endtask
  task automatic do_reset();
    i_rst_n <= 1'b0;
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
  endtask
  function automatic logic [1:0] res(input logic [3:0] t, input logic [7:0] n1,
                                     input logic [7:0] n2);
    return {{2'h0, t, 2'h0} > n2, {2'h0, t, 2'h0} > n1};
  endfunction
  function automatic logic [7:0] odd();
    return {1'b0, 6'($urandom_range(47)), 1'b1};
  endfunction
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      $display("mismatch timeout expected finish seen hang");
      conclude();
    end
  end

  // ----------------
  // tests
  // ----------------
  initial begin
    void'($urandom(32'h4DD87BE8));
    do_reset();
    for (int i = 0; i < 6; i++) begin
      get(ofs_t[i]);
      check_reg("reset value", rst_t[i], rd);
    end
    put(8'h3F, 8'hA5);
    get(8'h3F);
    check_reg("unmapped", 8'h00, rd);
    $display("test reset done");
    for (int m = 0; m < 8; m++) begin
      put(8'h9C, {5'h18, m[2:0]});
      get(8'h9C);
      check_reg("mode", {5'h0, m[2:0]}, (m == 0 || m == 7) ? rd : {2'h0, rd[5:0]});
    end
    $display("test modes done");
    for (int k = 0; k < 6; k++) begin
      tap = 4'($urandom_range(15));
      inv = 2'($urandom);
      sw = k[0];
      v = odd();
      put(8'h9D, {4'hA, tap});
      lvl[0] <= odd();
      lvl[3] <= odd();
      lvl[1] <= v;
      lvl[2] <= v;
      put(8'h9C, {2'h0, inv, sw, 3'h2});
      settle();
      get(8'h9C);
      e = res(tap, sw ? lvl[3] : lvl[0], lvl[2]);
      check_reg("internal ref result", {e ^ inv, inv, sw, 3'h2}, rd);
      check_pin("ref to positive", 1'b1, o_mux_sel.ref_to_positive);
      check_reg("neg pin", {6'h0, sw ? 2'h3 : 2'h0}, {6'h0, o_mux_sel.first_neg_pin});
    end
    $display("test internal reference done");
    put(8'h9D, 8'hA8);
    lvl[0] <= 8'h01;
    lvl[3] <= 8'h01;
    settle();
    get(8'h9C);
    put(8'h0D, 8'h00);
    get(8'h0D);
    check_reg("flag after relatch", 8'h00, rd);
    lvl[0] <= 8'h5F;
    lvl[3] <= 8'h5F;
    settle();
    get(8'h0D);
    check_reg("flag on change", 8'h40, rd);
    put(8'h0D, 8'h00);
    get(8'h0D);
    check_reg("flag under mismatch", 8'h40, rd);
    get(8'h9C);
    put(8'h0D, 8'h00);
    get(8'h0D);
    check_reg("flag cleared", 8'h00, rd);
    put(8'h0D, 8'h40);
    get(8'h0D);
    check_reg("flag set by write", 8'h40, rd);
    for (int k = 0; k < 8; k++) begin
      put(8'h8D, {1'b0, k[0], 6'h00});
      put(8'h0B, {k[2], k[1], 6'h00});
      @(negedge i_clk_sys);
      check_pin("irq", k == 7, o_irq);
    end
    $display("test change flag done");
    get(8'h9C);
    put(8'h0D, 8'h00);
    i_sleep <= 1'b1;
    slow <= 1'b1;
    lvl[0] <= 8'h01;
    lvl[3] <= 8'h01;
    settle();
    @(negedge i_clk_sys);
    check_pin("wake", 1'b1, o_wake);
    put(8'h9C, 8'h07);
    @(negedge i_clk_sys);
    check_pin("no wake when off", 1'b0, o_wake);
    put(8'h9C, {2'h0, inv, sw, 3'h2});
    @(posedge i_clk_sys);
    i_sleep <= 1'b0;
    slow <= 1'b0;
    settle();
    get(8'h9C);
    check_reg("ctrl after wake", {res(4'h8, 8'h01, lvl[2]) ^ inv, inv, sw, 3'h2}, rd);
    $display("test sleep done");
    pins = 8'($urandom);
    i_porta_pins <= pins;
    settle();
    get(8'h05);
    check_reg("port read", pins & 8'h80, rd);
    put(8'h9B, 8'h0F);
    get(8'h05);
    check_reg("port read", pins & 8'hF0, rd);
    put(8'h8D, 8'h00);
    put(8'h9C, {2'h0, inv, 4'h6});
    put(8'h85, 8'hE7);
    @(negedge i_clk_sys);
    check_reg("pin drive enables", 8'h18, o_porta_oe & 8'h18);
    @(posedge i_clk_sys);
    lvl <= {odd(), odd(), odd(), odd()};
    pos <= odd();
    #1;
    check_pin("pin three", raw[0] ^ inv[0], o_porta_out[3]);
    check_pin("pin four", raw[1] ^ inv[1], o_porta_out[4]);
    put(8'h85, 8'hFF);
    @(negedge i_clk_sys);
    check_reg("pin drive enables", 8'h00, o_porta_oe & 8'h18);
    $display("test pins done");
    put(8'h9D, 8'hFF);
    get(8'h9D);
    check_reg("ladder", 8'hEF, rd);
    @(negedge i_clk_sys);
    check_pin("ladder pin", 1'b1, o_ladder_pin_drive);
    put(8'h9D, 8'h40);
    @(negedge i_clk_sys);
    check_pin("ladder pin", 1'b0, o_ladder_pin_drive);
    put(8'h9C, 8'h15);
    do_reset();
    get(8'h9C);
    check_reg("ctrl after reset", 8'h07, rd);
    $display("test ladder and reset done");
    conclude();
  end
endmodule
